// >>> ptp_timestamp_capture_adjust.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ptp_timestamp_capture_adjust #(
   parameter int IDX_W = 14
) (
   input  wire logic       SYS_CLK,
   input  wire logic       RESETN,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic       TX_SOF,
   input  wire logic       TX_STAMP_REQUEST_BIT,
   input  wire logic       RX_VALID,
   input  wire logic       RX_SOF,
   input  wire logic [7:0] RX_DATA,
   input  wire logic       RX_EOF,
   output logic            RX_DESC_VALID,
   output logic      [3:0] RX_PACKET_KIND_FIELD,
   output logic            RX_STAMP_TAKEN_FLAG
);
   ptp_pkg::cfg_s    cfg, next_cfg;
   ptp_pkg::inc_s    inc, next_inc;
   ptp_pkg::rx_cap_s rx_cap, next_rx_cap;
   ptp_pkg::kind_e   kind, next_kind;
   logic [7:0]       cnt, next_cnt;
   logic [63:0]      sys, next_sys;
   logic [31:0]      hi_latch, next_hi_latch;
   logic [31:0]      adj_lo, next_adj_lo;
   logic [63:0]      tx_stamp, next_tx_stamp;
   logic             tx_lock, next_tx_lock;
   logic             rx_lock, next_rx_lock;
   logic [31:0]      next_rdata;
   logic             next_desc_v, next_desc_taken;
   logic [3:0]       next_desc_kind;
   logic [IDX_W-1:0] idx, next_idx;
   logic [IDX_W-1:0] base, next_base;
   logic [IDX_W-1:0] pbase, next_pbase;
   logic [7:0]       et_hi, next_et_hi;
   logic [7:0]       port_hi, next_port_hi;
   logic             port_ok, next_port_ok;
   logic [3:0]       ver, next_ver;
   logic [3:0]       msg, next_msg;
   logic [7:0]       ctl, next_ctl;
   logic [63:0]      src, next_src;
   logic [15:0]      seq, next_seq;
   logic             got, next_got;
   logic [63:0]      sof_time, next_sof_time;
   logic             evt, rec, msg_ok, take;
   logic [63:0]      inc_add, mag, sysv;
   logic [IDX_W-1:0] i, bs, rel;
   logic [15:0]      et;
   always_comb begin
      next_cfg = cfg;
      next_inc = inc;
      next_adj_lo = adj_lo;
      next_hi_latch = hi_latch;
      next_tx_stamp = tx_stamp;
      next_tx_lock = tx_lock;
      next_rx_cap = rx_cap;
      next_rx_lock = rx_lock;
      next_rdata = 32'h0000_0000;
      next_desc_v = 1'b0;
      next_desc_kind = ptp_pkg::KIND_NONE;
      next_desc_taken = 1'b0;
      next_idx = idx;
      next_base = base;
      next_kind = kind;
      next_pbase = pbase;
      next_et_hi = et_hi;
      next_port_hi = port_hi;
      next_port_ok = port_ok;
      next_ver = ver;
      next_msg = msg;
      next_ctl = ctl;
      next_src = src;
      next_seq = seq;
      next_got = got;
      next_sof_time = sof_time;
      et = {et_hi, RX_DATA};
      // Increment event every period; period 0 behaves as 1
      evt = (inc.per <= 8'h01) || (cnt >= inc.per - 8'h01);
      next_cnt = evt ? 8'h00 : cnt + 8'h01;
      inc_add = evt ? {40'h0, inc.val} : 64'h0;
      mag = {1'b0, REG_WDATA[30:0], adj_lo};
      sysv = sys + inc_add;
      if (REG_WR) begin
         unique case (REG_ADDR)
            ptp_pkg::CTRL_OFS: begin
               next_cfg = ptp_pkg::cfg_s'(REG_WDATA);
               next_cfg.rsv = 5'h00;
            end
            ptp_pkg::INC_OFS:    next_inc = ptp_pkg::inc_s'(REG_WDATA);
            ptp_pkg::SYS_LO_OFS: sysv[31:0] = REG_WDATA;
            ptp_pkg::SYS_HI_OFS: sysv[63:32] = REG_WDATA;
            ptp_pkg::ADJ_LO_OFS: next_adj_lo = REG_WDATA;
            ptp_pkg::ADJ_HI_OFS: begin
               sysv = REG_WDATA[ptp_pkg::ADJ_SIGN_BIT] ? sysv - mag : sysv + mag;
            end
            default: ;
         endcase
      end
      next_sys = sysv;
      if (REG_RD) begin
         unique case (REG_ADDR)
            ptp_pkg::CTRL_OFS:   next_rdata = cfg;
            ptp_pkg::INC_OFS:    next_rdata = inc;
            ptp_pkg::SYS_LO_OFS: begin
               next_rdata = sys[31:0];
               next_hi_latch = sys[63:32];
            end
            ptp_pkg::SYS_HI_OFS: next_rdata = hi_latch;
            ptp_pkg::ADJ_LO_OFS: next_rdata = adj_lo;
            ptp_pkg::TX_LO_OFS:  next_rdata = tx_stamp[31:0];
            ptp_pkg::TX_HI_OFS: begin
               next_rdata = tx_stamp[63:32];
               next_tx_lock = 1'b0;
            end
            ptp_pkg::RX_LO_OFS:  next_rdata = rx_cap.stamp[31:0];
            ptp_pkg::RX_HI_OFS: begin
               next_rdata = rx_cap.stamp[63:32];
               next_rx_lock = 1'b0;
            end
            ptp_pkg::SRC_LO_OFS: next_rdata = rx_cap.src[31:0];
            ptp_pkg::SRC_HI_OFS: next_rdata = rx_cap.src[63:32];
            ptp_pkg::SEQ_OFS:    next_rdata = {16'h0000, rx_cap.seq};
            ptp_pkg::STATUS_OFS: next_rdata = {30'h0, rx_lock, tx_lock};
            default: ;
         endcase
      end
      if (TX_SOF && TX_STAMP_REQUEST_BIT && cfg.tx_en && !tx_lock) begin
         next_tx_stamp = sys;
         next_tx_lock = 1'b1;
      end
      // Receive parser, one byte per valid cycle
      i = RX_SOF ? '0 : idx;
      bs = RX_SOF ? IDX_W'(ptp_pkg::L2_HDR) : base;
      rel = i - pbase;
      if (RX_VALID) begin
         next_idx = i + IDX_W'(1);
         if (RX_SOF) begin
            next_base = IDX_W'(ptp_pkg::L2_HDR);
            next_kind = ptp_pkg::K_NONE;
            next_port_ok = 1'b0;
            next_got = 1'b0;
            next_sof_time = sys;
         end
         if (i == bs - IDX_W'(2)) next_et_hi = RX_DATA;
         if (i == bs - IDX_W'(1)) begin
            if (et == ptp_pkg::ET_VLAN && bs == IDX_W'(ptp_pkg::L2_HDR)) begin
               next_base = bs + IDX_W'(ptp_pkg::VLAN_LEN);
            end else if (et == cfg.etype) begin
               next_kind = ptp_pkg::K_L2;
               next_pbase = bs;
               next_port_ok = 1'b1;
            end else if (et == ptp_pkg::ET_IPV4) begin
               next_kind = ptp_pkg::K_V4;
               next_pbase = bs + IDX_W'(ptp_pkg::IP4_PTP);
            end else if (et == ptp_pkg::ET_IPV6) begin
               next_kind = ptp_pkg::K_V6;
               next_pbase = bs + IDX_W'(ptp_pkg::IP6_PTP);
            end
         end
         if ((kind == ptp_pkg::K_V4 && i == base + IDX_W'(ptp_pkg::IP4_PROTO)) ||
             (kind == ptp_pkg::K_V6 && i == base + IDX_W'(ptp_pkg::IP6_NH))) begin
            if (RX_DATA != ptp_pkg::IP_UDP) next_kind = ptp_pkg::K_NONE;
         end
         if (kind == ptp_pkg::K_V4 || kind == ptp_pkg::K_V6) begin
            if (i == pbase - IDX_W'(ptp_pkg::UDP_DPORT_BACK)) next_port_hi = RX_DATA;
            if (i == pbase - IDX_W'(ptp_pkg::UDP_DPORT_BACK - 1)) begin
               next_port_ok = ({port_hi, RX_DATA} == ptp_pkg::UDP_EVENT);
            end
         end
         if (kind != ptp_pkg::K_NONE && i >= pbase) begin
            if (rel == IDX_W'(ptp_pkg::P_MSG)) next_msg = RX_DATA[3:0];
            if (rel == IDX_W'(ptp_pkg::P_VER)) next_ver = RX_DATA[3:0];
            if (rel >= IDX_W'(ptp_pkg::P_SRC) && rel <= IDX_W'(ptp_pkg::P_SRC_END)) begin
               next_src = {src[55:0], RX_DATA};
            end
            if (rel >= IDX_W'(ptp_pkg::P_SEQ) && rel <= IDX_W'(ptp_pkg::P_SEQ_END)) begin
               next_seq = {seq[7:0], RX_DATA};
            end
            if (rel == IDX_W'(ptp_pkg::P_CTRL)) begin
               next_ctl = RX_DATA;
               next_got = 1'b1;
            end
         end
      end
      // Frame end: decide stamp and descriptor marks
      rec = kind != ptp_pkg::K_NONE && port_ok && got &&
            (ver == ptp_pkg::VER2 || (ver == ptp_pkg::VER1 && kind == ptp_pkg::K_V4));
      if (ver == ptp_pkg::VER1) begin
         msg_ok = ctl == cfg.msg && ctl <= ptp_pkg::V1_DREQ;
      end else begin
         msg_ok = msg <= ptp_pkg::V2_PDRESP && (msg == cfg.msg[3:0] ||
                  (cfg.v2 && (msg == ptp_pkg::V2_PDREQ || msg == ptp_pkg::V2_PDRESP)));
      end
      take = cfg.rx_en && rec && msg_ok && !rx_lock;
      if (RX_EOF) begin
         next_desc_v = 1'b1;
         if (kind == ptp_pkg::K_L2) next_desc_kind = ptp_pkg::KIND_PTP;
         next_desc_taken = take;
         next_kind = ptp_pkg::K_NONE;
         if (take) begin
            next_rx_cap = '{stamp: sof_time, src: src, seq: seq};
            next_rx_lock = 1'b1;
         end
      end
   end
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg <= ptp_pkg::cfg_s'(ptp_pkg::CTRL_RST);
         inc <= ptp_pkg::inc_s'(ptp_pkg::INC_RST);
         rx_cap <= '0;
         kind <= ptp_pkg::K_NONE;
         cnt <= 8'h00;
         sys <= 64'h0;
         hi_latch <= 32'h0000_0000;
         adj_lo <= 32'h0000_0000;
         tx_stamp <= 64'h0;
         tx_lock <= 1'b0;
         rx_lock <= 1'b0;
         REG_RDATA <= 32'h0000_0000;
         RX_DESC_VALID <= 1'b0;
         RX_PACKET_KIND_FIELD <= ptp_pkg::KIND_NONE;
         RX_STAMP_TAKEN_FLAG <= 1'b0;
         idx <= '0;
         base <= IDX_W'(ptp_pkg::L2_HDR);
         pbase <= '0;
         et_hi <= 8'h00;
         port_hi <= 8'h00;
         port_ok <= 1'b0;
         ver <= 4'h0;
         msg <= 4'h0;
         ctl <= 8'h00;
         src <= 64'h0;
         seq <= 16'h0000;
         got <= 1'b0;
         sof_time <= 64'h0;
      end else begin
         cfg <= next_cfg;
         inc <= next_inc;
         rx_cap <= next_rx_cap;
         kind <= next_kind;
         cnt <= next_cnt;
         sys <= next_sys;
         hi_latch <= next_hi_latch;
         adj_lo <= next_adj_lo;
         tx_stamp <= next_tx_stamp;
         tx_lock <= next_tx_lock;
         rx_lock <= next_rx_lock;
         REG_RDATA <= next_rdata;
         RX_DESC_VALID <= next_desc_v;
         RX_PACKET_KIND_FIELD <= next_desc_kind;
         RX_STAMP_TAKEN_FLAG <= next_desc_taken;
         idx <= next_idx;
         base <= next_base;
         pbase <= next_pbase;
         et_hi <= next_et_hi;
         port_hi <= next_port_hi;
         port_ok <= next_port_ok;
         ver <= next_ver;
         msg <= next_msg;
         ctl <= next_ctl;
         src <= next_src;
         seq <= next_seq;
         got <= next_got;
         sof_time <= next_sof_time;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_lo_rd;
      REG_RD && REG_ADDR == ptp_pkg::SYS_LO_OFS;
   endsequence
   sequence s_hi_rd;
      REG_RD && REG_ADDR == ptp_pkg::SYS_HI_OFS;
   endsequence
   a_time_hi_latch: assert property (
      s_lo_rd ##1 s_hi_rd |=> REG_RDATA == $past(sys[63:32], 2))
      else $error("time high read did not return latched value");
   a_tx_capture: assert property (
      TX_SOF && TX_STAMP_REQUEST_BIT && cfg.tx_en && !tx_lock |=> tx_lock && tx_stamp == $past(sys))
      else $error("transmit stamp not captured");
   a_tx_no_req: assert property (
      !tx_lock && !(TX_SOF && TX_STAMP_REQUEST_BIT && cfg.tx_en) |=> !tx_lock)
      else $error("transmit lock set without request");
   a_tx_release: assert property (
      REG_RD && REG_ADDR == ptp_pkg::TX_HI_OFS |=> !tx_lock)
      else $error("transmit lock not released");
   a_rx_hold: assert property (
      rx_lock && !(REG_RD && REG_ADDR == ptp_pkg::RX_HI_OFS) |=> rx_lock && $stable(rx_cap))
      else $error("locked receive capture changed");
   a_rx_refuse: assert property (
      RX_EOF && rx_lock |=> RX_DESC_VALID && !RX_STAMP_TAKEN_FLAG)
      else $error("stamp taken while locked");
   a_rx_taken: assert property (
      RX_STAMP_TAKEN_FLAG |-> RX_DESC_VALID && rx_lock && rx_cap.stamp == $past(sof_time))
      else $error("stamp flag without capture");
   a_l2_kind: assert property (
      RX_EOF && kind == ptp_pkg::K_L2 |=> RX_PACKET_KIND_FIELD == ptp_pkg::KIND_PTP)
      else $error("layer-2 frame kind not reported");
   a_adj_add: assert property (
      REG_WR && REG_ADDR == ptp_pkg::ADJ_HI_OFS && !REG_WDATA[31]
      |=> sys == $past(sys) + $past(mag) + $past(inc_add))
      else $error("positive offset not added");
   a_adj_sub: assert property (
      REG_WR && REG_ADDR == ptp_pkg::ADJ_HI_OFS && REG_WDATA[31]
      |=> sys == $past(sys) + $past(inc_add) - $past(mag))
      else $error("negative offset not subtracted");
   a_inc_period: assert property (
      evt && inc.per == 8'h04 && !REG_WR ##1 !REG_WR [*3] |=> evt && !$past(evt))
      else $error("increment period wrong");
endmodule : ptp_timestamp_capture_adjust
`default_nettype wire

// >>> ptp_pkg.sv
`default_nettype none
package ptp_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] INC_OFS      = 8'h04;
   localparam logic [7:0] SYS_LO_OFS   = 8'h08;
   localparam logic [7:0] SYS_HI_OFS   = 8'h0C;
   localparam logic [7:0] ADJ_LO_OFS   = 8'h10;
   localparam logic [7:0] ADJ_HI_OFS   = 8'h14;
   localparam logic [7:0] TX_LO_OFS    = 8'h18;
   localparam logic [7:0] TX_HI_OFS    = 8'h1C;
   localparam logic [7:0] RX_LO_OFS    = 8'h20;
   localparam logic [7:0] RX_HI_OFS    = 8'h24;
   localparam logic [7:0] SRC_LO_OFS   = 8'h28;
   localparam logic [7:0] SRC_HI_OFS   = 8'h2C;
   localparam logic [7:0] SEQ_OFS      = 8'h30;
   localparam logic [7:0] STATUS_OFS   = 8'h34;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] INC_RST     = 32'h0100_0001;
   localparam int ADJ_SIGN_BIT         = 31;
   // Frame layout, byte offsets
   localparam int L2_HDR               = 14;
   localparam int VLAN_LEN             = 4;
   localparam int IP4_PROTO            = 9;
   localparam int IP4_PTP              = 28;
   localparam int IP6_NH               = 6;
   localparam int IP6_PTP              = 48;
   localparam int UDP_DPORT_BACK       = 6;
   localparam int P_MSG                = 0;
   localparam int P_VER                = 1;
   localparam int P_SRC                = 22;
   localparam int P_SRC_END            = 29;
   localparam int P_SEQ                = 30;
   localparam int P_SEQ_END            = 31;
   localparam int P_CTRL               = 32;
   localparam logic [15:0] ET_VLAN     = 16'h8100;
   localparam logic [15:0] ET_IPV4     = 16'h0800;
   localparam logic [15:0] ET_IPV6     = 16'h86DD;
   localparam logic [15:0] UDP_EVENT   = 16'h013F;
   localparam logic [7:0]  IP_UDP      = 8'h11;
   localparam logic [3:0]  VER1        = 4'h1;
   localparam logic [3:0]  VER2        = 4'h2;
   localparam logic [7:0]  V1_SYNC     = 8'h00;
   localparam logic [7:0]  V1_DREQ     = 8'h01;
   localparam logic [7:0]  V1_FUP      = 8'h02;
   localparam logic [7:0]  V1_DRESP    = 8'h03;
   localparam logic [7:0]  V1_MGMT     = 8'h04;
   localparam logic [3:0]  V2_PDREQ    = 4'h2;
   localparam logic [3:0]  V2_PDRESP   = 4'h3;
   localparam logic [3:0]  KIND_NONE   = 4'h0;
   localparam logic [3:0]  KIND_PTP    = 4'hE;
   typedef enum logic [1:0] {K_NONE, K_L2, K_V4, K_V6} kind_e;
   typedef struct packed {
      logic [15:0] etype;
      logic [7:0]  msg;
      logic [4:0]  rsv;
      logic        v2;
      logic        rx_en;
      logic        tx_en;
   } cfg_s;
   typedef struct packed {
      logic [7:0]  per;
      logic [23:0] val;
   } inc_s;
   typedef struct packed {
      logic [63:0] stamp;
      logic [63:0] src;
      logic [15:0] seq;
   } rx_cap_s;
endpackage : ptp_pkg
`default_nettype wire

// >>> ptp_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module ptp_phy_model (
   input  wire logic        SYS_CLK,
   input  wire logic [31:0] CYC,
   output logic             RX_VALID,
   output logic             RX_SOF,
   output logic [7:0]       RX_DATA,
   output logic             RX_EOF,
   output logic             TX_SOF,
   output logic             TX_STAMP_REQUEST_BIT
);
   logic busy;
   initial begin
      RX_VALID = 1'b0;
      RX_SOF = 1'b0;
      RX_DATA = 8'h5A;
      RX_EOF = 1'b0;
      TX_SOF = 1'b0;
      TX_STAMP_REQUEST_BIT = 1'b0;
      busy = 1'b0;
   end
   // Idle data keeps toggling so a stale byte never looks valid
   always @(posedge SYS_CLK) begin
      if (!busy) RX_DATA <= ~RX_DATA;
   end
   task automatic send_tx(input logic req, output logic [31:0] c);
      @(posedge SYS_CLK);
      TX_SOF <= 1'b1;
      TX_STAMP_REQUEST_BIT <= req;
      @(posedge SYS_CLK);
      c = CYC;
      TX_SOF <= 1'b0;
      TX_STAMP_REQUEST_BIT <= ~req;
   endtask : send_tx
   task automatic send_rx(input logic [7:0] f [0:99], input int n, output logic [31:0] c);
      busy = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge SYS_CLK);
         if (i == 1) c = CYC;
         RX_VALID <= 1'b1;
         RX_SOF <= (i == 0);
         RX_DATA <= f[i];
      end
      @(posedge SYS_CLK);
      RX_VALID <= 1'b0;
      RX_SOF <= 1'b0;
      RX_EOF <= 1'b1;
      @(posedge SYS_CLK);
      RX_EOF <= 1'b0;
      busy = 1'b0;
   endtask : send_rx
endmodule : ptp_phy_model
`default_nettype wire

// >>> tb_ptp_timestamp_capture_adjust.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ptp_timestamp_capture_adjust;
   localparam logic [15:0] ETH = 16'h88F7;
   logic        SYS_CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic [7:0]  REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   logic        TX_SOF, TX_STAMP_REQUEST_BIT, RX_VALID, RX_SOF, RX_EOF;
   logic [7:0]  RX_DATA;
   logic        RX_DESC_VALID, RX_STAMP_TAKEN_FLAG;
   logic [3:0]  RX_PACKET_KIND_FIELD;
   logic [31:0] cyc = 32'h0;
   logic [7:0]  frm [0:99];
   logic [31:0] v1, v2, c1, c2, s1, s2;
   int          errors = 0;
   int          comparisons = 0;
   always #2 SYS_CLK = ~SYS_CLK;
   always @(negedge SYS_CLK) cyc <= cyc + 32'h1;
   ptp_timestamp_capture_adjust i_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .TX_SOF(TX_SOF), .TX_STAMP_REQUEST_BIT(TX_STAMP_REQUEST_BIT), .RX_VALID(RX_VALID),
      .RX_SOF(RX_SOF), .RX_DATA(RX_DATA), .RX_EOF(RX_EOF), .RX_DESC_VALID(RX_DESC_VALID),
      .RX_PACKET_KIND_FIELD(RX_PACKET_KIND_FIELD), .RX_STAMP_TAKEN_FLAG(RX_STAMP_TAKEN_FLAG));
   ptp_phy_model i_phy (.SYS_CLK(SYS_CLK), .CYC(cyc), .RX_VALID(RX_VALID), .RX_SOF(RX_SOF),
      .RX_DATA(RX_DATA), .RX_EOF(RX_EOF), .TX_SOF(TX_SOF),
      .TX_STAMP_REQUEST_BIT(TX_STAMP_REQUEST_BIT));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [31:0] c);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      c = cyc;
      #1 d = REG_RDATA;
   endtask : rd
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d, c;
      rd(a, d, c);
      chk(d, exp);
   endtask : chk_rd
   function automatic logic [31:0] cfg(input logic v2m, input logic rx, input logic [7:0] m);
      return {ETH, m, 5'h00, v2m, rx, 1'b1};
   endfunction : cfg
   // Builds a frame, sends it and checks the descriptor it produces
   // Mode 0 layer 2, 1 UDP over IPv4, 2 tagged layer 2, 3 UDP over IPv6
   task automatic rxf(input int md, input logic [3:0] ver, input logic [7:0] b0,
                      input logic [7:0] ctl, input logic [3:0] kind, input logic flag);
      int p;
      p = (md == 0) ? 14 : (md == 1) ? 42 : (md == 2) ? 18 : 62;
      for (int i = 0; i < 100; i++) frm[i] = 8'h00;
      {frm[12], frm[13]} = (md == 1) ? ptp_pkg::ET_IPV4 : (md == 3) ? ptp_pkg::ET_IPV6 : ETH;
      if (md == 2) {frm[12], frm[13], frm[16], frm[17]} = {ptp_pkg::ET_VLAN, ETH};
      if (md == 1 || md == 3) begin
         frm[14] = (md == 1) ? 8'h45 : 8'h60;
         frm[(md == 1) ? 23 : 20] = ptp_pkg::IP_UDP;
         {frm[p - 6], frm[p - 5]} = ptp_pkg::UDP_EVENT;
      end
      frm[p] = b0;
      frm[p + 1] = {4'h0, ver};
      for (int i = 0; i < 8; i++) frm[p + 22 + i] = 8'hA0 + 8'(i);
      frm[p + 30] = 8'hBE;
      frm[p + 31] = 8'hEF;
      frm[p + 32] = ctl;
      i_phy.send_rx(frm, p + 36, s2);
      #1 chk({26'h0, RX_DESC_VALID, RX_PACKET_KIND_FIELD, RX_STAMP_TAKEN_FLAG},
             {26'h0, 1'b1, kind, flag});
   endtask : rxf
   task automatic tally_and_finish;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      chk_rd(ptp_pkg::INC_OFS, ptp_pkg::INC_RST);
      chk_rd(ptp_pkg::CTRL_OFS, ptp_pkg::CTRL_RST);
      chk_rd(8'h3C, 32'h0);
      $display("test reset done");
      wr(ptp_pkg::INC_OFS, {8'h04, 24'h8});
      rd(ptp_pkg::SYS_LO_OFS, v1, c1);
      repeat (38) @(posedge SYS_CLK);
      rd(ptp_pkg::SYS_LO_OFS, v2, c2);
      chk(v2 - v1, 32'd80);
      wr(ptp_pkg::INC_OFS, {8'h01, 24'h3});
      for (int s = 0; s < 2; s++) begin
         rd(ptp_pkg::SYS_LO_OFS, v1, c1);
         wr(ptp_pkg::ADJ_LO_OFS, 32'h100);
         wr(ptp_pkg::ADJ_HI_OFS, {s[0], 31'h0});
         rd(ptp_pkg::SYS_LO_OFS, v2, c2);
         chk(v2 - v1, (c2 - c1) * 3 + (s ? -32'h100 : 32'h100));
      end
      wr(ptp_pkg::SYS_LO_OFS, 32'h0);
      wr(ptp_pkg::SYS_HI_OFS, 32'h5A5A_0001);
      rd(ptp_pkg::SYS_LO_OFS, v1, c1);
      wr(ptp_pkg::SYS_HI_OFS, 32'h0000_0002);
      chk_rd(ptp_pkg::SYS_HI_OFS, 32'h5A5A_0001);
      // Low then high read with no gap between the strobes
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= ptp_pkg::SYS_LO_OFS;
      @(posedge SYS_CLK);
      REG_ADDR <= ptp_pkg::SYS_HI_OFS;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk(REG_RDATA, 32'h0000_0002);
      $display("test time done");
      wr(ptp_pkg::CTRL_OFS, cfg(1'b1, 1'b1, 8'h00));
      i_phy.send_tx(1'b0, s1);
      chk_rd(ptp_pkg::STATUS_OFS, 32'h0);
      i_phy.send_tx(1'b1, s1);
      i_phy.send_tx(1'b1, s2);
      chk_rd(ptp_pkg::STATUS_OFS, 32'h1);
      rd(ptp_pkg::TX_LO_OFS, v1, c1);
      rd(ptp_pkg::TX_HI_OFS, v2, c2);
      chk_rd(ptp_pkg::STATUS_OFS, 32'h0);
      i_phy.send_tx(1'b1, s2);
      rd(ptp_pkg::TX_LO_OFS, v2, c2);
      chk(v2 - v1, (s2 - s1) * 3);
      rd(ptp_pkg::TX_HI_OFS, v2, c2);
      $display("test transmit done");
      rxf(0, 4'h2, 8'h00, 8'h00, 4'hE, 1'b1);
      s1 = s2;
      rxf(0, 4'h2, 8'h00, 8'h00, 4'hE, 1'b0);
      chk_rd(ptp_pkg::SRC_HI_OFS, 32'hA0A1_A2A3);
      chk_rd(ptp_pkg::SRC_LO_OFS, 32'hA4A5_A6A7);
      chk_rd(ptp_pkg::SEQ_OFS, 32'h0000_BEEF);
      rd(ptp_pkg::RX_LO_OFS, v1, c1);
      rd(ptp_pkg::RX_HI_OFS, v2, c2);
      rxf(0, 4'h2, 8'h02, 8'h00, 4'hE, 1'b1);
      rd(ptp_pkg::RX_LO_OFS, v2, c2);
      chk(v2 - v1, (s2 - s1) * 3);
      rd(ptp_pkg::RX_HI_OFS, v2, c2);
      rxf(0, 4'h2, 8'h08, 8'h08, 4'hE, 1'b0);
      wr(ptp_pkg::CTRL_OFS, cfg(1'b0, 1'b1, 8'h00));
      foreach (frm[k]) if (k < 3) rxf(0, 4'h2, 8'h03 + 8'(k), 8'h00, 4'hE, 1'b0);
      for (int k = 0; k < 5; k++) begin
         wr(ptp_pkg::CTRL_OFS, cfg(1'b0, 1'b1, 8'(k)));
         rxf(1, 4'h1, 8'h00, 8'(k), 4'h0, k < 2);
         rd(ptp_pkg::RX_HI_OFS, v2, c2);
      end
      wr(ptp_pkg::CTRL_OFS, cfg(1'b0, 1'b1, 8'h01));
      rxf(0, 4'h1, 8'h00, 8'h01, 4'hE, 1'b0);
      rxf(3, 4'h1, 8'h00, 8'h01, 4'h0, 1'b0);
      rxf(3, 4'h2, 8'h01, 8'h01, 4'h0, 1'b1);
      rd(ptp_pkg::RX_HI_OFS, v2, c2);
      rxf(2, 4'h2, 8'h01, 8'h01, 4'hE, 1'b1);
      rd(ptp_pkg::RX_HI_OFS, v2, c2);
      wr(ptp_pkg::CTRL_OFS, cfg(1'b1, 1'b0, 8'h00));
      rxf(0, 4'h2, 8'h00, 8'h00, 4'hE, 1'b0);
      chk_rd(ptp_pkg::STATUS_OFS, 32'h0);
      $display("test receive done");
      wr(ptp_pkg::CTRL_OFS, cfg(1'b1, 1'b1, 8'h00));
      rxf(0, 4'h2, 8'h00, 8'h00, 4'hE, 1'b1);
      @(posedge SYS_CLK);
      RESETN <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      chk_rd(ptp_pkg::STATUS_OFS, 32'h0);
      chk_rd(ptp_pkg::CTRL_OFS, ptp_pkg::CTRL_RST);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule : tb_ptp_timestamp_capture_adjust
`default_nettype wire
